// *** rtl/ccl_top.v ***
// comparator control logic: mode decode, polarity, output pin and input switch with apb registers
//
// Behaviour
// - direction bit one means input, zero output
// - direction bits seven and six read zero
// - direction bit three always reads one
// - crystal clock modes force bits five, four one
// - clock source comes from three-bit select field
// - comparator result always readable in control register
// - result drives pin only in listed modes
// - invert bit inverts reported comparator result
// - inverting input higher gives zero, uninverted
// - register bit and pin carry same result
// - input switch only in listed mode codes
// - both switch candidate pins stay analog
// - input_select picks pin for inverting input
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ccl_defines.vh"

module ccl_top
#(
	parameter DUAL = 0    // 0: single comparator variant, 1: dual comparator variant
)
(
	input  wire        clk,
	input  wire        arst_n,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// analog comparator cells: raw result high when inverting input is the lower
	input  wire [1:0]  cmp_raw,
	// pin controls
	output reg  [5:0]  port_dir_n_oe,
	output reg  [1:0]  cmp_pin_out,
	output reg  [1:0]  cmp_pin_en,
	output reg  [1:0]  inv_in_sel,
	output reg  [1:0]  analog_keep,
	output reg  [2:0]  clk_src_sel,
	output reg         sync_gate_cmp,
	output reg         gate_src_sel
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg  [5:0] port_dir_ff;      // writable direction bits (3 is stored but always reads one)
reg  [7:0] cmp_ctrl_ff;      // mode, select and invert bits; result bits read live
reg  [1:0] sync_gate_ff;
reg  [2:0] clk_src_ff;
wire [1:0] cmp_sync;

wire       wr_en  = psel & penable & pwrite;
wire       acc_en = psel & penable;
wire [2:0] mode   = cmp_ctrl_ff[`CCL_CC_MODE_HI:`CCL_CC_MODE_LO];

// reset values cut to the widths that are really stored; the bits left out are
// either forced by the read view or absent altogether
localparam [7:0] RST_DIR_FULL  = `CCL_RST_PORT_DIR;
localparam [7:0] RST_GATE_FULL = `CCL_RST_SYNC_GATE;
localparam [5:0] RST_DIR       = RST_DIR_FULL[5:0];
localparam [1:0] RST_GATE      = RST_GATE_FULL[1:0];

// crystal clock source test, used for read-back and pin drive
function is_crystal;
	input [2:0] src;
	begin
		is_crystal = (src == `CCL_CLK_LP) || (src == `CCL_CLK_XT) || (src == `CCL_CLK_HS);
	end
endfunction

// known register offset test
function addr_hit;
	input [11:0] a;
	begin
		addr_hit = (a == `CCL_OFS_PORT_DIR) || (a == `CCL_OFS_CMP_CTRL) ||
			(a == `CCL_OFS_SYNC_GATE) || (a == `CCL_OFS_CLK_SRC);
	end
endfunction

// ----------------------------------------------------------------
// comparator result path
// ----------------------------------------------------------------
// raw comparator outputs are asynchronous to clk; the two flops add two cycles to
// the result bit and three to the pin, far below any analog settling time
ccl_sync2 #(.WIDTH(2)) u_sync
(
	.clk      (clk),
	.arst_n   (arst_n),
	.async_in (cmp_raw),
	.sync_out (cmp_sync)
);

// polarity adjust; one value feeds both register bit and pin
wire [1:0] cmp_pol = cmp_sync ^ {cmp_ctrl_ff[`CCL_CC_INV2], cmp_ctrl_ff[`CCL_CC_INV1]};

// output pin routing per variant; the single variant only routes comparator one,
// the dual variant routes both pins from one shared mode
reg [1:0] pin_route;
always @*
begin
	pin_route = 2'b00;
	if (DUAL == 0)
	begin
		if (mode == `CCL_MODE_001 || mode == `CCL_MODE_011 || mode == `CCL_MODE_101)
			pin_route = 2'b01;
	end
	else if (mode == `CCL_MODE_110)
		pin_route = 2'b11;
end

// inverting input switch availability per variant; bit one is only ever set in
// the dual variant, where one mode switches both comparators
reg [1:0] sw_avail;
always @*
begin
	sw_avail = 2'b00;
	if (DUAL == 0)
	begin
		if (mode == `CCL_MODE_101 || mode == `CCL_MODE_110)
			sw_avail = 2'b01;
	end
	else if (mode == `CCL_MODE_001)
		sw_avail = 2'b01;
	else if (mode == `CCL_MODE_010)
		sw_avail = 2'b11;
end

// ----------------------------------------------------------------
// register writes
// ----------------------------------------------------------------
// next register values; a write lands only at the edge where pready is high, so
// an access phase held longer stores again at every second edge; bit 3 is stored but reads one, the result bits
// are not stored, and an unmapped write falls through the decode untouched
reg [5:0] nxt_port_dir;
reg [7:0] nxt_cmp_ctrl;
reg [1:0] nxt_sync_gate;
reg [2:0] nxt_clk_src;
always @*
begin
	nxt_port_dir  = port_dir_ff;
	nxt_cmp_ctrl  = cmp_ctrl_ff;
	nxt_sync_gate = sync_gate_ff;
	nxt_clk_src   = clk_src_ff;
	if (wr_en && pready)
	begin
		if (paddr == `CCL_OFS_PORT_DIR)
			nxt_port_dir = pwdata[5:0];
		else if (paddr == `CCL_OFS_CMP_CTRL)
			nxt_cmp_ctrl = {2'b00, pwdata[5:0]};
		else if (paddr == `CCL_OFS_SYNC_GATE)
			nxt_sync_gate = pwdata[1:0];
		else if (paddr == `CCL_OFS_CLK_SRC)
			nxt_clk_src = pwdata[2:0];
	end
end

// comparator_control keeps [2:0] mode, [3] input select, [4] and [5] invert;
// comparator_sync_gate keeps [0] sync request and [1] gate source
always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		port_dir_ff  <= RST_DIR;
		cmp_ctrl_ff  <= `CCL_RST_CMP_CTRL;
		sync_gate_ff <= RST_GATE;
		clk_src_ff   <= `CCL_RST_CLK_SRC;
	end
	else
	begin
		port_dir_ff  <= nxt_port_dir;
		cmp_ctrl_ff  <= nxt_cmp_ctrl;
		sync_gate_ff <= nxt_sync_gate;
		clk_src_ff   <= nxt_clk_src;
	end
end

// ----------------------------------------------------------------
// read data
// ----------------------------------------------------------------
// read view of port_a_direction with the fixed bits forced, then the address mux
reg [7:0] dir_view;
reg [7:0] rd_mux;
always @*
begin
	dir_view = {2'b00, port_dir_ff};
	dir_view[`CCL_PD_INPUT_ONLY] = 1'b1;
	if (is_crystal(clk_src_ff))
	begin
		dir_view[`CCL_PD_OSC_HI] = 1'b1;
		dir_view[`CCL_PD_OSC_LO] = 1'b1;
	end
	rd_mux = 8'h00;
	if (paddr == `CCL_OFS_PORT_DIR)
		rd_mux = dir_view;
	else if (paddr == `CCL_OFS_CMP_CTRL)
		rd_mux = {(DUAL != 0) & cmp_pol[1], cmp_pol[0], cmp_ctrl_ff[5:0]};
	else if (paddr == `CCL_OFS_SYNC_GATE)
		rd_mux = {6'h00, sync_gate_ff};
	else if (paddr == `CCL_OFS_CLK_SRC)
		rd_mux = {5'h00, clk_src_ff};
end

// apb answer: pready rises one cycle into the access phase and stands one cycle;
// the wait state buys a registered prdata for the price of one bus cycle
reg [31:0] nxt_prdata;
reg        nxt_pready;
reg        nxt_pslverr;
always @*
begin
	nxt_pready  = 1'b0;
	nxt_pslverr = 1'b0;
	nxt_prdata  = 32'h0000_0000;
	if (acc_en && !pready)
	begin
		nxt_pready  = 1'b1;
		nxt_pslverr = ~addr_hit(paddr);
		// a write answers with zero data
		if (!pwrite)
			nxt_prdata = {24'h00_0000, rd_mux};
	end
end

// answer flops; outside the ready cycle all three rest at zero
always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		pready  <= 1'b0;
		pslverr <= 1'b0;
		prdata  <= 32'h0000_0000;
	end
	else
	begin
		pready  <= nxt_pready;
		pslverr <= nxt_pslverr;
		prdata  <= nxt_prdata;
	end
end

// ----------------------------------------------------------------
// pin side outputs
// ----------------------------------------------------------------
// next pin controls; the crystal pins stay inputs whatever the stored bits say,
// because the oscillator owns them in those modes
reg [5:0] nxt_port_dir_n_oe;
reg [1:0] nxt_cmp_pin_out;
reg [1:0] nxt_cmp_pin_en;
reg [1:0] nxt_inv_in_sel;
reg [1:0] nxt_analog_keep;
reg [2:0] nxt_clk_src_sel;
reg       nxt_sync_gate_cmp;
reg       nxt_gate_src_sel;
always @*
begin
	nxt_port_dir_n_oe = dir_view[5:0];
	nxt_cmp_pin_en    = pin_route;
	// an unrouted pin rests low instead of showing a stale result
	nxt_cmp_pin_out   = cmp_pol & pin_route;
	// zero picks the first pin, one the second; idle modes park on the first
	nxt_inv_in_sel    = sw_avail & {2{cmp_ctrl_ff[`CCL_CC_INSEL]}};
	nxt_analog_keep   = sw_avail;
	// clock source and gate bits are plain copies for the rest of the chip
	nxt_clk_src_sel   = clk_src_ff;
	nxt_sync_gate_cmp = sync_gate_ff[0];
	nxt_gate_src_sel  = sync_gate_ff[1];
end

// every pin control leaves through a flop so the pads never see decode glitches
always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		port_dir_n_oe <= 6'h3f;
		cmp_pin_out   <= 2'b00;
		cmp_pin_en    <= 2'b00;
		inv_in_sel    <= 2'b00;
		analog_keep   <= 2'b00;
		clk_src_sel   <= `CCL_RST_CLK_SRC;
		sync_gate_cmp <= 1'b0;
		gate_src_sel  <= 1'b0;
	end
	else
	begin
		port_dir_n_oe <= nxt_port_dir_n_oe;
		cmp_pin_en    <= nxt_cmp_pin_en;
		cmp_pin_out   <= nxt_cmp_pin_out;
		inv_in_sel    <= nxt_inv_in_sel;
		analog_keep   <= nxt_analog_keep;
		clk_src_sel   <= nxt_clk_src_sel;
		sync_gate_cmp <= nxt_sync_gate_cmp;
		gate_src_sel  <= nxt_gate_src_sel;
	end
end

endmodule

// *** rtl/ccl_defines.vh ***
// register offsets, field positions, reset values and mode codes of the comparator control logic
`ifndef CCL_DEFINES_VH
`define CCL_DEFINES_VH

// register byte offsets on the apb bus
`define CCL_OFS_PORT_DIR    12'h000
`define CCL_OFS_CMP_CTRL    12'h004
`define CCL_OFS_SYNC_GATE   12'h008
`define CCL_OFS_CLK_SRC     12'h00c

// reset values
`define CCL_RST_PORT_DIR    8'h3f
`define CCL_RST_CMP_CTRL    8'h00
`define CCL_RST_SYNC_GATE   8'h02
`define CCL_RST_CLK_SRC     3'h0

// comparator_control field positions
`define CCL_CC_MODE_LO      0
`define CCL_CC_MODE_HI      2
`define CCL_CC_INSEL        3
`define CCL_CC_INV1         4
`define CCL_CC_INV2         5
`define CCL_CC_RES1         6
`define CCL_CC_RES2         7

// port_a_direction fixed bits
`define CCL_PD_INPUT_ONLY   3
`define CCL_PD_OSC_LO       4
`define CCL_PD_OSC_HI       5
`define CCL_PD_IMPL_MASK    8'h3f

// comparator modes that touch the output pin or input switch
`define CCL_MODE_001        3'h1
`define CCL_MODE_010        3'h2
`define CCL_MODE_011        3'h3
`define CCL_MODE_101        3'h5
`define CCL_MODE_110        3'h6

// clock source codes; the three crystal modes force the oscillator pins to input
`define CCL_CLK_LP          3'h0
`define CCL_CLK_XT          3'h1
`define CCL_CLK_HS          3'h2

`endif

// *** rtl/ccl_sync2.v ***
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module ccl_sync2
#(
	parameter WIDTH = 2
)
(
	input  wire             clk,
	input  wire             arst_n,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_ff;
reg [WIDTH-1:0] sync_ff;

// first stage feeds only the second stage
always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		meta_ff <= {WIDTH{1'b0}};
		sync_ff <= {WIDTH{1'b0}};
	end
	else
	begin
		meta_ff <= async_in;
		sync_ff <= meta_ff;
	end
end

assign sync_out = sync_ff;

endmodule

// *** tb/ccl_monitor.sv ***
// port-level assertions for the comparator control logic
`timescale 1ns/1ps
module ccl_monitor
(
	input wire        clk,
	input wire        arst_n,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [1:0]  cmp_raw,
	input wire [5:0]  port_dir_n_oe,
	input wire [1:0]  cmp_pin_out,
	input wire [1:0]  cmp_pin_en,
	input wire [1:0]  inv_in_sel,
	input wire [1:0]  analog_keep,
	input wire [2:0]  clk_src_sel
);
	// ----
	// completed transfers
	// ----
	wire wr = psel & penable & pready & pwrite;
	wire rd = psel & penable & pready & ~pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_PIN_EN: assert property (wr && paddr == 12'h004 |-> ##2
		cmp_pin_en[0] == ($past(pwdata[2:0], 2) inside {3'h1, 3'h3, 3'h5}))
		else $error("pin enable");
	AST_SWITCH: assert property (wr && paddr == 12'h004 |-> ##2
		{analog_keep[0], inv_in_sel[0]} == (($past(pwdata[2:0], 2) inside {3'h5, 3'h6}) ?
		{1'b1, $past(pwdata[3], 2)} : 2'b00)) else $error("input switch");
	AST_DIR_WR: assert property (wr && paddr == 12'h000 |-> ##2
		port_dir_n_oe[3] && port_dir_n_oe[2:0] == $past(pwdata[2:0], 2))
		else $error("direction");
	AST_RD_DIR: assert property (rd && paddr == 12'h000 |->
		prdata[31:6] == 26'h0 && prdata[3]) else $error("direction read");
	AST_OSC: assert property (clk_src_sel <= 3'h2 |->
		port_dir_n_oe[5:4] == 2'b11) else $error("oscillator pins");
	AST_OFF: assert property ((cmp_pin_out & ~cmp_pin_en) == 2'b00)
		else $error("pin not routed");
	AST_SAME: assert property (($stable(cmp_raw) [*4] ##0 rd && paddr == 12'h004 &&
		cmp_pin_en[0]) |-> prdata[6] == cmp_pin_out[0]) else $error("pin and bit differ");
	AST_READY: assert property (psel && penable && !pready |=> pready) else $error("no ready");
	AST_UNMAP: assert property (pready && paddr > 12'h00c |-> pslverr && prdata == 32'h0)
		else $error("unmapped");
endmodule
bind ccl_top ccl_monitor u_mon (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .cmp_raw, .port_dir_n_oe, .cmp_pin_out, .cmp_pin_en,
	.inv_in_sel, .analog_keep, .clk_src_sel);

// *** tb/ccl_top_bench.sv ***
// self-checking bench for the comparator control logic
`timescale 1ns/1ps
module ccl_top_bench;
	logic        clk;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  cmp_raw;
	logic [5:0]  port_dir_n_oe;
	logic [1:0]  cmp_pin_out;
	logic [1:0]  cmp_pin_en;
	logic [1:0]  inv_in_sel;
	logic [1:0]  analog_keep;
	logic [2:0]  clk_src_sel;
	logic        sync_gate_cmp;
	logic        gate_src_sel;
	logic [31:0] rd;
	logic        err;
	integer      err_total = 0;
	integer      checks = 0;
	ccl_top dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cmp_raw, .port_dir_n_oe, .cmp_pin_out, .cmp_pin_en, .inv_in_sel,
		.analog_keep, .clk_src_sel, .sync_gate_cmp, .gate_src_sel);
	// ----
	// clock, checks and bus cycle
	// ----
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task wrap_up;
		begin
			$display("checks %0d errors %0d", checks, err_total);
			if (err_total == 0 && checks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task chk(input logic [63:0] g, input logic [63:0] e);
		begin
			checks++;
			if (g !== e)
			begin
				err_total++;
				$display("Error at %0t: got %h want %h", $time, g, e);
			end
		end
	endtask
	// one apb transfer; a fresh edge first so psel is never set twice in one step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		integer n;
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (pready !== 1'b1 && n < 9);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			if (pready !== 1'b1)
			begin
				chk(0, 1);
				wrap_up;
			end
		end
	endtask
	// ----
	// scenarios
	// ----
	task t_reset;
		begin
			apb(0, 12'h000, 0);
			chk(rd, 32'h3f);
			apb(0, 12'h004, 0);
			chk(rd, 32'h0);
			apb(0, 12'h010, 0);
			chk({err, rd}, 33'h100000000);
			apb(0, 12'h008, 0);
			chk(rd, 32'h2);
			apb(1, 12'h008, 1);
			apb(0, 12'h008, 0);
			chk({rd, sync_gate_cmp, gate_src_sel}, 34'h6);
		end
	endtask
	// crystal codes force the oscillator pins to input, code 3 does not
	task t_dir;
		logic [31:0] e;
		begin
			for (int i = 0; i < 4; i++)
			begin
				apb(1, 12'h00c, i);
				apb(1, 12'h000, 32'hc5);
				apb(0, 12'h000, 0);
				e = (i < 3) ? 32'h3d : 32'h0d;
				chk(rd, e);
				chk(port_dir_n_oe, e[5:0]);
			end
		end
	endtask
	// every mode with both invert and select levels, result read and pin compared
	task t_modes;
		logic [2:0] m;
		logic       b;
		logic       r;
		logic       pe;
		logic       sw;
		begin
			// comparator output pin made driven before any routing mode is chosen
			apb(1, 12'h000, 32'h3b);
			apb(0, 12'h000, 0);
			chk({rd, port_dir_n_oe}, {32'h3b, 6'h3b});
			for (int i = 0; i < 16; i++)
			begin
				{m, b} = i;
				r = i[2] ^ i[0];
				apb(1, 12'h004, {b, b, m});
				cmp_raw <= {1'b0, r};
				apb(0, 12'h004, 0);
				pe = (m == 3'h1 || m == 3'h3 || m == 3'h5);
				sw = (m == 3'h5 || m == 3'h6);
				chk(rd, {r ^ b, 1'b0, b, b, m});
				chk({cmp_pin_en, cmp_pin_out}, {1'b0, pe, 1'b0, pe & (r ^ b)});
				chk({analog_keep, inv_in_sel}, {1'b0, sw, 1'b0, sw & b});
			end
		end
	endtask
	// reset in mid-run returns the direction, control and sync gate registers and every pin control to their reset values
	task t_rearm;
		begin
			@(posedge clk);
			arst_n <= 1'b0;
			@(posedge clk);
			chk({port_dir_n_oe, cmp_pin_en, cmp_pin_out}, 64'h3f0);
			chk({inv_in_sel, analog_keep, clk_src_sel, sync_gate_cmp, gate_src_sel}, 0);
			arst_n <= 1'b1;
			apb(0, 12'h000, 0);
			chk(rd, 32'h3f);
			apb(0, 12'h004, 0);
			chk(rd, 32'h0);
			apb(0, 12'h008, 0);
			chk({rd, sync_gate_cmp, gate_src_sel}, 34'h9);
		end
	endtask
	initial
	begin
		arst_n = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		cmp_raw = 0;
		repeat (5) @(posedge clk);
		arst_n <= 1;
		t_reset;
		t_dir;
		t_modes;
		t_rearm;
		wrap_up;
	end
endmodule
